/* verilog/mpseq_pkg.sv */
// mpseq_pkg: shared constants and carriers for the power on/off sequencer
// assumes a 25 MHz system clock; times are kept in their own unit and turned into cycles here
package mpseq_pkg;
   localparam int unsigned CLK_HZ         = 25_000_000;
   localparam int unsigned HOLD_MS        = 1000;   // power toggle least hold time
   localparam int unsigned BOOT_MS        = 900;    // software startup after status rises
   localparam int unsigned EOFF_MS        = 200;    // emergency-off least hold time
   localparam int unsigned HOLD_CYC       = (CLK_HZ / 1000) * HOLD_MS;
   localparam int unsigned BOOT_CYC       = (CLK_HZ / 1000) * BOOT_MS;
   localparam int unsigned EOFF_CYC       = (CLK_HZ / 1000) * EOFF_MS;
   localparam int unsigned CNT_W          = 32;

   typedef enum logic [2:0] {
      MPSEQ_OFF      = 3'h0,
      MPSEQ_SUPPLY   = 3'h1,
      MPSEQ_BOOT     = 3'h3,
      MPSEQ_ON       = 3'h2,
      MPSEQ_WAIT_REL = 3'h6,
      MPSEQ_DETACH   = 3'h7,
      MPSEQ_DOWN     = 3'h5
   } mpseq_state_t;

   // pin levels as seen by the device; each open-collector pin is read as a plain level
   typedef struct packed {
      logic pwr_key_n;
      logic eoff_n;
   } mpseq_pins_t;
endpackage

/* verilog/mpseq_lowtimer.sv */
// mpseq_lowtimer: measures how long an active-low input has stayed low
// assumes the input is already synchronous to clk_sys
`timescale 1ns/10ps
module mpseq_lowtimer
   import mpseq_pkg::*;
#(
   parameter int unsigned LIMIT = 1000
) (
   // clock and reset
   input  wire logic clk_sys,
   input  wire logic rst,
   // level in, qualified level out
   input  wire logic level_n,
   output logic      long_low
);
   typedef struct packed {
      logic [CNT_W-1:0] cnt;
      logic             hit;
   } mpseq_lt_t;

   mpseq_lt_t s_q, s_d;

   always_comb begin
      s_d = s_q;
      if (level_n) begin
         s_d.cnt = '0;
         s_d.hit = 1'b0;
      end else if (s_q.cnt < CNT_W'(LIMIT)) begin
         s_d.cnt = s_q.cnt + CNT_W'(1);
      end else begin
         s_d.hit = 1'b1;
      end
   end

   always_ff @(posedge clk_sys) begin
      if (rst) begin
         s_q <= '0;
      end else begin
         s_q <= s_d;
      end
   end

   assign long_low = s_q.hit;
endmodule

/* verilog/mpseq_top.sv */
// mpseq_top: device-side power on/off sequencer driven by a power toggle pin and an emergency-off pin
// assumes pins are synchronous to clk_sys and pulled up inside the device; the host only pulls them low
`timescale 1ns/10ps
module mpseq_top
   import mpseq_pkg::*;
#(
   parameter int unsigned HOLD_CYCLES = HOLD_CYC,
   parameter int unsigned BOOT_CYCLES = BOOT_CYC,
   parameter int unsigned EOFF_CYCLES = EOFF_CYC
) (
   // clock and reset
   input  wire logic  clk_sys,
   input  wire logic  rst,
   // host-facing pins
   input  wire mpseq_pins_t pins,
   output logic        pwr_status,
   // internal radio side
   input  wire logic  supply_good,
   input  wire logic  sw_off_req,
   input  wire logic  detach_done,
   output logic        supply_en,
   output logic        sw_ready,
   output logic        detach_req,
   output logic        forced_off
);
   typedef struct packed {
      mpseq_state_t     st;
      logic [CNT_W-1:0] cnt;
      logic             status;
      logic             supply;
      logic             ready;
      logic             detach;
      logic             forced;
      logic             eoff_seen;
   } mpseq_top_t;

   mpseq_top_t s_q, s_d;
   logic       key_long;
   logic       eoff_long;

   mpseq_lowtimer #(.LIMIT(HOLD_CYCLES)) u_key (
      .clk_sys  (clk_sys),
      .rst      (rst),
      .level_n  (pins.pwr_key_n),
      .long_low (key_long)
   );

   mpseq_lowtimer #(.LIMIT(EOFF_CYCLES)) u_eoff (
      .clk_sys  (clk_sys),
      .rst      (rst),
      .level_n  (pins.eoff_n),
      .long_low (eoff_long)
   );

   always_comb begin
      s_d        = s_q;
      s_d.forced = 1'b0;
      // emergency-off is acted on at release, like the toggle's off request (power-on acts at the qualified hold), after a qualified hold
      if (eoff_long) begin
         s_d.eoff_seen = 1'b1;
      end
      if (s_q.eoff_seen && pins.eoff_n) begin
         s_d.eoff_seen = 1'b0;
         if (s_q.st != MPSEQ_OFF) begin
            // no detach: drop everything at once
            s_d.st     = MPSEQ_OFF;
            s_d.supply = 1'b0;
            s_d.status = 1'b0;
            s_d.ready  = 1'b0;
            s_d.detach = 1'b0;
            s_d.forced = 1'b1;
         end
      end else begin
         case (s_q.st)
            MPSEQ_OFF: begin
               // start once the hold qualifies; the host may keep holding through boot
               if (key_long) begin
                  s_d.st     = MPSEQ_SUPPLY;
                  s_d.supply = 1'b1;
               end
            end
            MPSEQ_SUPPLY: begin
               if (supply_good) begin
                  s_d.status = 1'b1;
                  s_d.cnt    = '0;
                  s_d.st     = MPSEQ_BOOT;
               end
            end
            MPSEQ_BOOT: begin
               if (s_q.cnt < CNT_W'(BOOT_CYCLES)) begin
                  s_d.cnt = s_q.cnt + CNT_W'(1);
               end else begin
                  s_d.ready = 1'b1;
                  // a key still held from power-on must be released before it can mean off
                  s_d.st    = pins.pwr_key_n ? MPSEQ_ON : MPSEQ_WAIT_REL;
               end
            end
            MPSEQ_WAIT_REL: begin
               if (pins.pwr_key_n) begin
                  s_d.st = MPSEQ_ON;
               end
            end
            MPSEQ_ON: begin
               if (sw_off_req) begin
                  s_d.st     = MPSEQ_DETACH;
                  s_d.detach = 1'b1;
               end else if (key_long) begin
                  s_d.st = MPSEQ_DOWN;
               end
            end
            MPSEQ_DOWN: begin
               // qualified off request waits for the release
               if (pins.pwr_key_n) begin
                  s_d.st     = MPSEQ_DETACH;
                  s_d.detach = 1'b1;
               end
            end
            MPSEQ_DETACH: begin
               if (detach_done) begin
                  s_d.detach = 1'b0;
                  s_d.supply = 1'b0;
                  s_d.ready  = 1'b0;
                  s_d.status = 1'b0;
                  s_d.st     = MPSEQ_OFF;
               end
            end
            default: begin
               s_d = '0;
            end
         endcase
      end
   end

   always_ff @(posedge clk_sys) begin
      if (rst) begin
         s_q <= '0;
      end else begin
         s_q <= s_d;
      end
   end

   assign pwr_status = s_q.status;
   assign supply_en  = s_q.supply;
   assign sw_ready   = s_q.ready;
   assign detach_req = s_q.detach;
   assign forced_off = s_q.forced;
endmodule

/* test/mpseq_checker.sv */
// mpseq_checker: port-level properties of the power sequencer
// assumes one clock domain, bound onto mpseq_top from the bench
`timescale 1ns/10ps
module mpseq_checker
   import mpseq_pkg::*;
(
   // clock and reset
   input wire logic        clk_sys,
   input wire logic        rst,
   // watched ports
   input wire mpseq_pins_t pins,
   input wire logic        pwr_status,
   input wire logic        supply_good,
   input wire logic        sw_off_req,
   input wire logic        detach_done,
   input wire logic        supply_en,
   input wire logic        sw_ready,
   input wire logic        detach_req,
   input wire logic        forced_off
);
   default clocking @(posedge clk_sys); endclocking
   default disable iff (rst);
   a_status_on_supply: assert property ($rose(pwr_status) |-> $past(supply_good) && supply_en)
      else $error("status rose without supply");
   a_ready_after_boot: assert property ($rose(sw_ready) |-> $past(pwr_status, 8))
      else $error("ready too soon after status");
   a_on_after_hold: assert property ($rose(supply_en) |-> !$past(pins.pwr_key_n, 8))
      else $error("power on without long key hold");
   a_off_on_release: assert property ($rose(detach_req) |-> $past(pins.pwr_key_n) || $past(sw_off_req))
      else $error("detach while key still held");
   a_off_cause: assert property ($fell(pwr_status) |-> forced_off || $past(detach_req))
      else $error("status fell without detach");
   a_detach_end: assert property ($fell(detach_req) |-> $past(detach_done) || forced_off)
      else $error("detach dropped early");
   a_forced_clean: assert property (forced_off |-> !detach_req && !pwr_status && !supply_en)
      else $error("forced off left outputs up");
   a_forced_pulse: assert property (forced_off |=> !forced_off)
      else $error("forced off longer than one cycle");
   c_forced: cover property (forced_off);
   c_ready: cover property ($rose(sw_ready));
   c_detach: cover property ($rose(detach_req));
endmodule

/* test/mpseq_host.sv */
// mpseq_host: host side driving both open-collector pins
// assumes the device pulls each pin up, so a released pin reads high
`timescale 1ns/10ps
module mpseq_host
   import mpseq_pkg::*;
(
   input  wire logic  clk_sys,
   output mpseq_pins_t pins
);
   initial pins = '1;
   // holds a pin low for n whole cycles; n rounds the minimum up
   task press(input bit e, input int n);
      @(posedge clk_sys);
      #1;
      if (e) pins.eoff_n = 1'b0;
      else pins.pwr_key_n = 1'b0;
      repeat (n) @(posedge clk_sys);
   endtask
   // release only, never driven high; both pins go back up together, eoff included
   task rel();
      @(posedge clk_sys);
      #1 pins = '1;
   endtask
endmodule

/* test/tb_top.sv */
// tb_top: scenario bench for mpseq_top with a host model on the pins
// assumes short cycle counts stand in for the real hold and boot times
`timescale 1ns/10ps
module tb_top;
   import mpseq_pkg::*;
   localparam int H = 20, B = 15, E = 5;
   logic        clk_sys = 0, rst = 1, supply_good = 0, sw_off_req = 0, detach_done = 0;
   logic        pwr_status, supply_en, sw_ready, detach_req, forced_off;
   mpseq_pins_t pins;
   int          n_mismatch = 0, tests_run = 0;
   always #20 clk_sys = ~clk_sys;
   mpseq_host host (.clk_sys(clk_sys), .pins(pins));
   mpseq_top #(.HOLD_CYCLES(H), .BOOT_CYCLES(B), .EOFF_CYCLES(E)) uut (.clk_sys(clk_sys), .rst(rst),
      .pins(pins), .pwr_status(pwr_status), .supply_good(supply_good), .sw_off_req(sw_off_req),
      .detach_done(detach_done), .supply_en(supply_en), .sw_ready(sw_ready), .detach_req(detach_req),
      .forced_off(forced_off));
   task test_done();
      $display("mismatches %0d of %0d checks", n_mismatch, tests_run);
      if (n_mismatch == 0 && tests_run > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask
   task chk(input logic g, input logic x);
      tests_run++;
      if (g !== x) begin
         $display("unexpected at %0t: got %h exp %h", $time, g, x);
         n_mismatch++;
      end
   endtask
   // bounded wait for a level; a hang ends the run
   task automatic wt(ref logic s, input logic v);
      int i;
      for (i = 0; i < 200 && s !== v; i++) begin
         @(posedge clk_sys);
         #1;
      end
      chk(s, v);
      if (s !== v) test_done();
   endtask
   task power_on();
      int c;
      host.press(0, H);
      wt(supply_en, 1);
      supply_good = 1;
      wt(pwr_status, 1);
      for (c = 0; c < 100 && sw_ready !== 1'b1; c++) begin
         @(posedge clk_sys);
         #1;
      end
      chk(c >= B && c < 100, 1);
      host.rel();
      chk(detach_req, 0);
   endtask
   task finish_detach();
      wt(detach_req, 1);
      chk(pwr_status, 1);
      detach_done = 1;
      wt(pwr_status, 0);
      detach_done = 0;
      supply_good = 0;
      chk(sw_ready | supply_en | detach_req | forced_off, 0);
   endtask
   task key_off();
      power_on();
      host.press(0, H + 4);
      chk(pwr_status, 1);
      chk(detach_req, 0);
      host.rel();
      finish_detach();
   endtask
   task sw_off();
      power_on();
      // let the release edge move the state to ON first, else the command lands in WAIT_REL and is dropped
      @(posedge clk_sys);
      #1 sw_off_req = 1;
      @(posedge clk_sys);
      #1 sw_off_req = 0;
      finish_detach();
   endtask
   task emergency();
      power_on();
      host.press(1, E + 3);
      chk(pwr_status, 1);
      host.rel();
      wt(forced_off, 1);
      chk(detach_req | pwr_status | sw_ready | supply_en, 0);
      supply_good = 0;
   endtask
   initial begin
      repeat (12) @(posedge clk_sys);
      #1 rst = 0;
      key_off();
      sw_off();
      emergency();
      power_on();
      test_done();
   end
endmodule
bind mpseq_top mpseq_checker u_chk (.clk_sys(clk_sys), .rst(rst), .pins(pins), .pwr_status(pwr_status),
   .supply_good(supply_good), .sw_off_req(sw_off_req), .detach_done(detach_done), .supply_en(supply_en),
   .sw_ready(sw_ready), .detach_req(detach_req), .forced_off(forced_off));
